// [rtl/fpu_pkg.sv]
// Purpose: constants and types for the page unprotect / discard block
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes:   small array model, 8 pages of 4 words

// =============================================================
// package
package fpu_pkg;

	// =========================================================
	// array geometry
	localparam int PAGES  = 8;
	localparam int PAGE_W = 3;
	localparam int WORDS  = 4;
	localparam int WIDX_W = 2;
	localparam int DATA_W = 32;
	localparam int AI_W   = PAGE_W + WIDX_W;
	localparam int AW     = 5;

	// =========================================================
	// register byte offsets
	localparam logic [AW-1:0] OFF_STAT = 5'h00;
	localparam logic [AW-1:0] OFF_ISTS = 5'h04;
	localparam logic [AW-1:0] OFF_IMSK = 5'h08;
	localparam logic [AW-1:0] OFF_BIDX = 5'h0c;
	localparam logic [AW-1:0] OFF_BDAT = 5'h10;
	localparam logic [AW-1:0] OFF_PROG = 5'h14;
	localparam logic [AW-1:0] OFF_INFO = 5'h18;
	localparam logic [AW-1:0] OFF_FLT  = 5'h1c;

	// =========================================================
	// field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_ST   = 1;
	localparam int STAT_MOD  = 3;
	localparam int STAT_VAL  = 4;
	localparam int STAT_PG   = 8;
	localparam int PROG_LOCK = 8;
	localparam int INFO_LOCK = 0;
	localparam int FLT_CODE  = 0;
	localparam int FLT_BLK   = 4;
	localparam int FLT_PG    = 8;
	localparam int IRQ_UNP   = 0;
	localparam int IRQ_DROP  = 1;
	localparam int IRQ_ERR   = 2;
	localparam int IRQ_W     = 3;

	// =========================================================
	// status codes and reset values
	localparam logic [1:0] ST_OK     = 2'h0;
	localparam logic [1:0] ST_SBE    = 2'h1;
	localparam logic [1:0] ST_LOCKED = 2'h1;
	localparam logic [1:0] ST_DBE    = 2'h2;
	localparam logic [1:0] ST_HOLD   = 2'h3;
	localparam logic [IRQ_W-1:0] IMSK_RST = 3'h0;

	// =========================================================
	// types
	typedef enum logic [1:0] {
		S_IDLE,
		S_COPY,
		S_DROP,
		S_PROG
	} fpu_state_type;

	typedef struct packed {
		logic              page_unprotect_req;
		logic              buffer_drop_req;
		logic              buffer_hold_guard;
		logic [PAGE_W-1:0] addr;
	} fpu_req_type;

endpackage : fpu_pkg

// [rtl/fpu_page_ctrl.sv]
// Purpose: page unprotect and page discard control of the user flash
// Assumes: user pins synchronous to mclk, Avalon-MM register slave
// Notes:   array is a small model with an injectable fault map

`timescale 1ns/10ps

module fpu_page_ctrl (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// user fabric side
	input  wire fpu_pkg::fpu_req_type  user_req,
	output logic                       busy,
	output logic [1:0]                 status,
	// register bus
	input  wire logic [4:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	// interrupt
	output logic                       irq
);

	// =========================================================
	// storage and state
	logic [31:0]               arr_q [fpu_pkg::PAGES*fpu_pkg::WORDS];
	logic [1:0]                flt_q [fpu_pkg::PAGES*fpu_pkg::WORDS];
	logic [31:0]               buf_q [fpu_pkg::WORDS];
	logic [fpu_pkg::PAGES-1:0] lock_q;
	fpu_pkg::fpu_state_type    state_q, state_d;
	logic [fpu_pkg::WIDX_W-1:0] idx_q;
	logic [fpu_pkg::PAGE_W-1:0] op_pg_q, bpg_q, info_pg_q;
	logic [fpu_pkg::WIDX_W-1:0] bidx_q;
	logic                      op_lock_q, mod_q, bval_q;
	logic [1:0]                st_q, st_d, err_q, err_d;
	logic [fpu_pkg::IRQ_W-1:0] ists_q, ists_d, imsk_q, imsk_d, ev;
	logic                      wait_q, busy_q, irq_q;
	logic [31:0]               rd_q, rd_d;
	logic                      done_unp, done_drop, prog_ref;

	// =========================================================
	// decode
	logic                      acc, wr, last, miss, guarded;
	logic                      take_unp, take_drop, take_prog, buf_wr;
	logic [fpu_pkg::AI_W-1:0]  ai;
	logic [fpu_pkg::PAGE_W-1:0] prog_pg;

	// bus access happens on the edge where waitrequest is low
	assign acc = (avs_read | avs_write) & ~wait_q;
	assign wr  = acc & avs_write;
	assign buf_wr = wr & (avs_address == fpu_pkg::OFF_BDAT);
	assign prog_pg = avs_writedata[fpu_pkg::PAGE_W-1:0];
	assign last = (idx_q == fpu_pkg::WIDX_W'(fpu_pkg::WORDS - 1));
	assign ai   = {op_pg_q, idx_q};

	// page hit test and loss protection of the buffer
	assign miss    = ~bval_q | (user_req.addr != bpg_q);
	assign guarded = user_req.buffer_hold_guard & mod_q;

	// request acceptance, unprotect first, then discard, then program
	assign take_unp  = (state_q == fpu_pkg::S_IDLE) &
		user_req.page_unprotect_req;
	assign take_drop = (state_q == fpu_pkg::S_IDLE) &
		~user_req.page_unprotect_req & user_req.buffer_drop_req;
	assign take_prog = (state_q == fpu_pkg::S_IDLE) &
		~user_req.page_unprotect_req & ~user_req.buffer_drop_req &
		wr & (avs_address == fpu_pkg::OFF_PROG);

	// =========================================================
	// operation sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			fpu_pkg::S_IDLE: begin
				if (take_unp) begin
					if (miss && !guarded) begin
						state_d = fpu_pkg::S_COPY;
					end
				end else if (take_drop) begin
					state_d = fpu_pkg::S_DROP;
				end else if (take_prog && !lock_q[prog_pg]) begin
					state_d = fpu_pkg::S_PROG;
				end
			end
			fpu_pkg::S_COPY, fpu_pkg::S_PROG: begin
				if (last) begin
					state_d = fpu_pkg::S_IDLE;
				end
			end
			fpu_pkg::S_DROP: begin
				state_d = fpu_pkg::S_IDLE;
			end
			default: begin
				state_d = fpu_pkg::S_IDLE;
			end
		endcase
	end

	// state, word counter, target page; busy follows next state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q   <= fpu_pkg::S_IDLE;
			idx_q     <= '0;
			op_pg_q   <= '0;
			op_lock_q <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != fpu_pkg::S_IDLE);
			if (state_q == fpu_pkg::S_IDLE) begin
				idx_q <= '0;
			end else begin
				idx_q <= idx_q + 1'b1;
			end
			if (take_unp) begin
				op_pg_q <= user_req.addr;
			end else if (take_prog) begin
				op_pg_q   <= prog_pg;
				op_lock_q <= avs_writedata[fpu_pkg::PROG_LOCK];
			end
		end
	end

	// =========================================================
	// array, fault map and page locks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lock_q <= '0;
			for (int i = 0; i < fpu_pkg::PAGES * fpu_pkg::WORDS; i++) begin
				arr_q[i] <= '0;
				flt_q[i] <= '0;
			end
		end else begin
			if (take_unp) begin
				lock_q[user_req.addr] <= 1'b0;
			end
			if (state_q == fpu_pkg::S_PROG) begin
				arr_q[ai] <= buf_q[idx_q];
				flt_q[ai] <= '0;
				if (last) begin
					lock_q[op_pg_q] <= op_lock_q;
				end
			end
			if (wr && avs_address == fpu_pkg::OFF_FLT) begin
				flt_q[{avs_writedata[fpu_pkg::FLT_PG +: fpu_pkg::PAGE_W],
					avs_writedata[fpu_pkg::FLT_BLK +: fpu_pkg::WIDX_W]}]
					<= avs_writedata[fpu_pkg::FLT_CODE +: 2];
			end
		end
	end

	// =========================================================
	// page buffer and its bookkeeping
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < fpu_pkg::WORDS; i++) begin
				buf_q[i] <= '0;
			end
			mod_q  <= 1'b0;
			bval_q <= 1'b0;
			bpg_q  <= '0;
			bidx_q <= '0;
		end else begin
			if (state_q == fpu_pkg::S_COPY) begin
				buf_q[idx_q] <= arr_q[ai];
			end
			if ((state_q == fpu_pkg::S_COPY ||
				state_q == fpu_pkg::S_PROG) && last) begin
				bpg_q  <= op_pg_q;
				bval_q <= 1'b1;
				mod_q  <= 1'b0;
			end
			if (state_q == fpu_pkg::S_DROP) begin
				mod_q <= 1'b0;
			end
			if (wr && avs_address == fpu_pkg::OFF_BIDX) begin
				bidx_q <= avs_writedata[fpu_pkg::WIDX_W-1:0];
			end
			// a buffer write in the same cycle wins over the clear
			if (buf_wr) begin
				buf_q[bidx_q] <= avs_writedata;
				mod_q         <= 1'b1;
			end
		end
	end

	// =========================================================
	// status code and completion events
	always_comb begin
		st_d      = st_q;
		err_d     = err_q;
		done_unp  = 1'b0;
		done_drop = (state_q == fpu_pkg::S_DROP);
		prog_ref  = 1'b0;
		if (take_unp) begin
			err_d = '0;
			if (miss && guarded) begin
				st_d     = fpu_pkg::ST_HOLD;
				done_unp = 1'b1;
			end else if (!miss) begin
				st_d     = fpu_pkg::ST_OK;
				done_unp = 1'b1;
			end
		end else if (take_drop) begin
			st_d = fpu_pkg::ST_OK;
		end else if (take_prog) begin
			prog_ref = lock_q[prog_pg];
			st_d = prog_ref ? fpu_pkg::ST_LOCKED : fpu_pkg::ST_OK;
		end
		if (state_q == fpu_pkg::S_COPY) begin
			err_d = err_q | flt_q[ai];
			if (last) begin
				done_unp = 1'b1;
				if (err_d[1]) begin
					st_d = fpu_pkg::ST_DBE;
				end else if (err_d[0]) begin
					st_d = fpu_pkg::ST_SBE;
				end else begin
					st_d = fpu_pkg::ST_OK;
				end
			end
		end
	end

	// completion events feeding the interrupt status
	always_comb begin
		ev = '0;
		ev[fpu_pkg::IRQ_UNP]  = done_unp;
		ev[fpu_pkg::IRQ_DROP] = done_drop;
		ev[fpu_pkg::IRQ_ERR]  = (done_unp | prog_ref) &
			(st_d != fpu_pkg::ST_OK);
	end

	// status holder
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q  <= fpu_pkg::ST_OK;
			err_q <= '0;
		end else begin
			st_q  <= st_d;
			err_q <= err_d;
		end
	end

	// =========================================================
	// interrupt status and mask, write one to clear, set wins
	always_comb begin
		ists_d = ists_q;
		imsk_d = imsk_q;
		if (wr && avs_address == fpu_pkg::OFF_ISTS) begin
			ists_d = ists_q & ~avs_writedata[fpu_pkg::IRQ_W-1:0];
		end
		if (wr && avs_address == fpu_pkg::OFF_IMSK) begin
			imsk_d = avs_writedata[fpu_pkg::IRQ_W-1:0];
		end
		ists_d = ists_d | ev;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ists_q <= '0;
			imsk_q <= fpu_pkg::IMSK_RST;
			irq_q  <= 1'b0;
		end else begin
			ists_q <= ists_d;
			imsk_q <= imsk_d;
			irq_q  <= |(ists_d & imsk_d);
		end
	end

	// =========================================================
	// register read mux
	always_comb begin
		rd_d = '0;
		case (avs_address)
			fpu_pkg::OFF_STAT: begin
				rd_d[fpu_pkg::STAT_BUSY] = busy_q;
				rd_d[fpu_pkg::STAT_ST +: 2] = st_q;
				rd_d[fpu_pkg::STAT_MOD] = mod_q;
				rd_d[fpu_pkg::STAT_VAL] = bval_q;
				rd_d[fpu_pkg::STAT_PG +: fpu_pkg::PAGE_W] = bpg_q;
			end
			fpu_pkg::OFF_ISTS: rd_d[fpu_pkg::IRQ_W-1:0] = ists_q;
			fpu_pkg::OFF_IMSK: rd_d[fpu_pkg::IRQ_W-1:0] = imsk_q;
			fpu_pkg::OFF_BIDX: rd_d[fpu_pkg::WIDX_W-1:0] = bidx_q;
			fpu_pkg::OFF_BDAT: rd_d = buf_q[bidx_q];
			fpu_pkg::OFF_INFO: begin
				rd_d[fpu_pkg::INFO_LOCK] = lock_q[info_pg_q];
			end
			default: rd_d = '0;
		endcase
	end

	// one wait cycle per access, read data captured as wait drops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_q    <= 1'b1;
			rd_q      <= '0;
			info_pg_q <= '0;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if (avs_read && wait_q) begin
				rd_q <= rd_d;
			end
			if (wr && avs_address == fpu_pkg::OFF_INFO) begin
				info_pg_q <= avs_writedata[fpu_pkg::PAGE_W-1:0];
			end
		end
	end

	// =========================================================
	// outputs
	assign busy            = busy_q;
	assign status          = st_q;
	assign avs_readdata    = rd_q;
	assign avs_waitrequest = wait_q;
	assign irq             = irq_q;

	// =========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic info_bit_h;
	assign info_bit_h = lock_q[info_pg_q];

	sequence copy_end_s;
		state_q == fpu_pkg::S_COPY && last;
	endsequence

	sequence drop_walk_s;
		take_drop ##1 state_q == fpu_pkg::S_DROP && !buf_wr;
	endsequence

	AST_UNP_CLEARS: assert property (
		take_unp && !take_prog |=> !lock_q[op_pg_q] ##1
			!lock_q[$past(op_pg_q)])
		else $error("unprotect left page locked");

	AST_COPY_MISS: assert property (
		take_unp && miss && !guarded |=> state_q == fpu_pkg::S_COPY
			##3 state_q == fpu_pkg::S_COPY ##1 bval_q &&
			bpg_q == op_pg_q)
		else $error("missed page not copied");

	AST_GUARD_NOLOAD: assert property (
		take_unp && miss && guarded |=> state_q == fpu_pkg::S_IDLE &&
			st_q == fpu_pkg::ST_HOLD && bpg_q == $past(bpg_q))
		else $error("guarded buffer overwritten");

	AST_SBE: assert property (
		copy_end_s and (!err_d[1] && err_d[0]) |=>
			st_q == fpu_pkg::ST_SBE && !busy_q)
		else $error("correctable error not reported");

	AST_HOLD: assert property (
		take_unp && miss && guarded |=> status == 2'h3 ##1
			status == 2'h3 || !busy_q)
		else $error("guard status missing");

	AST_DBE: assert property (
		copy_end_s and (err_d[1] && !buf_wr) |=> st_q == fpu_pkg::ST_DBE &&
			bval_q && !mod_q)
		else $error("uncorrectable error not reported");

	AST_DROP: assert property (
		drop_walk_s |=> !mod_q && st_q == fpu_pkg::ST_OK)
		else $error("discard left buffer modified");

	AST_BUSY_DROP: assert property (
		take_drop |=> busy && state_q == fpu_pkg::S_DROP ##1 !busy)
		else $error("busy wrong during discard");

	AST_PROG_LOCK: assert property (
		take_prog && lock_q[prog_pg] |=>
			state_q == fpu_pkg::S_IDLE && st_q == fpu_pkg::ST_LOCKED
			&& !busy_q)
		else $error("locked page accepted program");

	AST_INFO: assert property (
		avs_read && wait_q && avs_address == fpu_pkg::OFF_INFO |=>
			avs_readdata[0] == $past(info_bit_h) && !avs_waitrequest)
		else $error("page info lock bit wrong");

endmodule : fpu_page_ctrl

// [verif/fpu_user_model.sv]
// Purpose: user fabric model driving the unprotect and discard pins
// Assumes: pins sampled by the block at each rising mclk
// Notes:   released address and guard show the inverted last value
`timescale 1ns/10ps
// ==========================================================
// user logic model
module fpu_user_model (
	// clock
	input  wire logic            mclk,
	// block status
	input  wire logic            busy,
	// request pins
	output fpu_pkg::fpu_req_type user_req
);
	// pins idle from time zero
	initial user_req = '0;

	// one request pulse, once busy is low or after 100 waiting cycles
	task automatic issue(input logic unp, drop, guard,
		input logic [2:0] pg);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		user_req <= '{unp, drop, guard, pg};
		@(posedge mclk);
		user_req <= '{1'b0, 1'b0, ~guard, ~pg};
	endtask : issue
endmodule : fpu_user_model

// [verif/test_fpu_page_ctrl.sv]
// Purpose: self-checking bench for page unprotect and discard
// Assumes: 20 MHz mclk, one wait state on the register bus
// Notes:   integer model of buffer, locks and faults
`timescale 1ns/10ps
// ==========================================================
// bench top
module test_fpu_page_ctrl;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	fpu_pkg::fpu_req_type user_req;
	logic                 busy;
	logic [1:0]           status;
	logic [4:0]           avs_address = 5'h00;
	logic                 avs_read = 1'b0;
	logic                 avs_write = 1'b0;
	logic [31:0]          avs_writedata = 32'h0;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	logic                 irq;
	logic [31:0]          q;
	int                   errors = 0;
	int                   total_checks = 0;
	int                   lk[8], flt[8], bp, bv, bm, st, n;

	// 50 ns clock
	always #25 mclk = ~mclk;

	// block and user model
	fpu_page_ctrl dut (.mclk(mclk), .rst(rst), .user_req(user_req),
		.busy(busy), .status(status), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq));
	fpu_user_model user (.mclk(mclk), .busy(busy), .user_req(user_req));

	// ======================================================
	// checks and verdict
	task automatic chk_reg(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: register %h not %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: pin %h not %h", $time, got, exp);
		end
	endtask : chk_pin
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// ======================================================
	// register bus master, holds until waitrequest low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		if (k >= 50)
			chk_pin(32'h1, 32'h0);
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// ======================================================
	// model and operations
	task automatic m_reset;
		foreach (lk[i]) begin
			lk[i] = 0;
			flt[i] = 0;
		end
		{bp, bv, bm, st} = '0;
	endtask : m_reset
	task automatic stat;
		rd(fpu_pkg::OFF_STAT);
		chk_reg(q, 32'((bp << fpu_pkg::STAT_PG) | (bv << fpu_pkg::STAT_VAL)
			| (bm << fpu_pkg::STAT_MOD) | (st << fpu_pkg::STAT_ST)));
	endtask : stat
	// count busy cycles, then let status settle
	task automatic run;
		n = 0;
		#1;
		while (busy === 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
	endtask : run
	task automatic unp(input logic g, input logic [2:0] p);
		int nb;
		nb = 0;
		st = 0;
		if (!(bv == 1 && p == bp) && g && bm == 1)
			st = 3;
		else if (!(bv == 1 && p == bp)) begin
			{bp, bv, bm, nb} = {32'(p), 32'h1, 32'h0, 32'h4};
			st = flt[p][1] ? 2 : flt[p][0];
		end
		lk[p] = 0;
		user.issue(1'b1, 1'b0, g, p);
		run();
		chk_pin(32'(n), 32'(nb));
		chk_pin({30'h0, status}, 32'(st));
	endtask : unp
	task automatic prog(input logic l, input logic [2:0] p);
		st = lk[p] ? 1 : 0;
		if (lk[p] == 0)
			{lk[p], bp, bv, bm, flt[p]} = {32'(l), 32'(p), 32'h1, 64'h0};
		wr(fpu_pkg::OFF_PROG, {23'h0, l, 5'h0, p});
		repeat (2) @(posedge mclk);
		run();
		chk_pin({30'h0, status}, 32'(st));
	endtask : prog
	task automatic info(input logic [2:0] p);
		wr(fpu_pkg::OFF_INFO, {29'h0, p});
		rd(fpu_pkg::OFF_INFO);
		chk_reg(q & 32'h1, 32'(lk[p]));
	endtask : info
	task automatic irq_is(input logic e);
		@(posedge mclk);
		#1;
		chk_pin({31'h0, irq}, {31'h0, e});
	endtask : irq_is

	// ======================================================
	// watchdog
	initial begin
		#2000000;
		chk_pin(32'h1, 32'h0);
		give_verdict();
	end

	// ======================================================
	// main sequence
	initial begin
		void'($urandom(32'h470bf5e9));
		m_reset();
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		stat();
		rd(fpu_pkg::OFF_IMSK);
		chk_reg(q, {29'h0, fpu_pkg::IMSK_RST});
		rd(5'h1e);
		chk_reg(q, 32'h0);
		// lock, refused overwrite, unprotect
		prog(1'b1, 3'h2);
		info(3'h2);
		prog(1'b0, 3'h2);
		unp(1'b0, 3'h5);
		unp(1'b0, 3'h2);
		info(3'h2);
		// single and double bit faults
		wr(fpu_pkg::OFF_FLT, 32'h611);
		wr(fpu_pkg::OFF_FLT, 32'h732);
		{flt[6], flt[7]} = {32'h1, 32'h2};
		unp(1'b0, 3'h6);
		unp(1'b0, 3'h7);
		stat();
		// random edits, guards and pages
		for (int i = 0; i < 10; i++) begin
			wr(fpu_pkg::OFF_BDAT, $urandom());
			bm = 1;
			unp(1'($urandom()), 3'($urandom()));
			stat();
		end
		// discard with interrupt
		wr(fpu_pkg::OFF_ISTS, 32'h7);
		wr(fpu_pkg::OFF_IMSK, 32'h2);
		wr(fpu_pkg::OFF_BDAT, $urandom());
		user.issue(1'b0, 1'b1, 1'b0, 3'h0);
		run();
		chk_pin(32'(n), 32'h1);
		rd(fpu_pkg::OFF_STAT);
		chk_reg(q & 32'h18, 32'h10);
		irq_is(1'b1);
		wr(fpu_pkg::OFF_IMSK, 32'h0);
		irq_is(1'b0);
		wr(fpu_pkg::OFF_IMSK, 32'h2);
		irq_is(1'b1);
		wr(fpu_pkg::OFF_ISTS, 32'h2);
		irq_is(1'b0);
		// reset in the middle of a copy, off the clock edge
		user.issue(1'b1, 1'b0, 1'b0, 3'(bp + 1));
		@(negedge mclk);
		rst <= 1'b1;
		#1;
		chk_pin({29'h0, busy, status}, 32'h0);
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		m_reset();
		stat();
		give_verdict();
	end
endmodule : test_fpu_page_ctrl
